// file: pkg/dpc_pkg.sv
// package: timing constants and request types for the dual-port ram host
// What this block does
// - keep select or r/w high on address change
// - write recovery counted from first rising control
// - stretch pulse to float plus setup when oe low
// - wait busy access time before r/w falls
// - never drive data while ram outputs active, except in write recovery with oe low
// - busy input asserted by start of write
// - hold write after busy releases
package dpc_pkg;
  localparam int CLK_MHZ       = 200;
  localparam int T_AS_NS       = 0;   // address setup
  localparam int T_WP_NS       = 15;  // write pulse width
  localparam int T_WZ_NS       = 10;  // write enable to output float
  localparam int T_DW_NS       = 10;  // data valid to end of write
  localparam int T_WR_NS       = 0;   // write recovery
  localparam int T_DH_NS       = 0;   // data hold
  localparam int T_BAA_NS      = 20;  // busy access from address
  localparam int T_WH_NS       = 12;  // write hold after busy
  localparam int T_AA_NS       = 20;  // read access
  localparam int T_BDD_NS      = 25;  // busy disable to valid data
  localparam int T_HZ_NS       = 10;  // output float after read
  localparam int ADDR_W        = 11;
  localparam int DATA_W        = 8;

  // least time rounded up to whole cycles, at least one
  function automatic int cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int C_AS  = cyc(T_AS_NS);
  localparam int C_WP  = cyc(T_WP_NS);
  localparam int C_WZD = cyc(T_WZ_NS + T_DW_NS);
  localparam int C_DW  = cyc(T_DW_NS);
  localparam int C_WR  = cyc(T_WR_NS + T_DH_NS);
  localparam int C_BAA = cyc(T_BAA_NS);
  localparam int C_WH  = cyc(T_WH_NS);
  localparam int C_RD  = cyc(T_AA_NS);
  localparam int C_BDD = cyc(T_BDD_NS);
  localparam int C_HZ  = cyc(T_HZ_NS);
  localparam int CNT_W = 6;

  typedef struct packed {
    logic              wr;    // 1 write, 0 read
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dpc_req_t;

  typedef struct packed {
    logic              done;     // one-cycle pulse
    logic              blocked;  // access saw busy; a write may be lost
    logic [DATA_W-1:0] rdata;
  } dpc_rsp_t;

  typedef struct packed {
    logic              sel_n;
    logic              rw_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
  } dpc_pins_t;
endpackage

// file: logic/dpc_host.sv
// one port master for the asynchronous dual-port ram
`timescale 1ns/1ps
module dpc_host #(
  parameter int OE_LOW_WRITE = 0   // keep output enable low in writes
) (
  input  wire logic              clk_sys,  // 200 MHz clock
  input  wire logic              srst,     // sync reset, high
  input  wire logic              req_valid, // request strobe
  input  wire dpc_pkg::dpc_req_t req,      // request payload
  output logic                   req_ready, // idle, can take request
  output dpc_pkg::dpc_rsp_t      rsp,      // answer
  output dpc_pkg::dpc_pins_t     pins,     // ram control pins
  output logic [dpc_pkg::DATA_W-1:0] dq_o, // data to ram
  output logic                   dq_oe,    // high while driving data
  input  wire logic [dpc_pkg::DATA_W-1:0] dq_i, // data from ram
  input  wire logic              busy_n_pin // busy from ram, low active
);
  typedef enum {
    S_IDLE, S_ADDR, S_BUSYW, S_WPULSE, S_WHOLD, S_RECOV,
    S_READ, S_RBDD, S_RFLOAT
  } dpc_state_t;

  dpc_state_t                   st, next_st;
  logic [dpc_pkg::CNT_W-1:0]    cnt, next_cnt;
  dpc_pkg::dpc_req_t            cur, next_cur;
  dpc_pkg::dpc_rsp_t            next_rsp;
  dpc_pkg::dpc_pins_t           next_pins;
  logic [dpc_pkg::DATA_W-1:0]   next_dq_o;
  logic                         next_dq_oe, next_ready;
  logic                         busy_s1, busy_s2, blk, next_blk;

  // cycle count as counter width
  function automatic logic [dpc_pkg::CNT_W-1:0] cw(input int c);
    return dpc_pkg::CNT_W'(c);
  endfunction

  // busy pin resynchronised
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
    end else begin
      busy_s1 <= busy_n_pin;
      busy_s2 <= busy_s1;
    end
  end

  // sequencer next state
  always_comb begin
    next_st   = st;
    next_cnt  = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_cur  = cur;
    next_pins = pins;
    next_dq_o = dq_o;
    next_dq_oe = dq_oe;
    next_ready = 1'b0;
    next_blk  = blk;
    next_rsp  = '0;
    next_rsp.rdata = rsp.rdata;
    case (st)
      S_IDLE: begin
        next_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_cur  = req;
          next_blk  = 1'b0;
          next_ready = 1'b0;
          // address moves only with r/w high; select falls on the same edge
          next_pins.addr  = req.addr;
          next_pins.sel_n = 1'b0;
          next_pins.oe_n  = req.wr ? (OE_LOW_WRITE == 0) : 1'b0;
          next_cnt = cw(dpc_pkg::C_AS);
          next_st  = req.wr ? S_ADDR : S_READ;
          if (!req.wr)
            next_cnt = cw(dpc_pkg::C_RD);
        end
      end
      S_ADDR: begin
        if (cnt == '0) begin
          next_cnt = cw(dpc_pkg::C_BAA);
          next_st  = S_BUSYW;
        end
      end
      S_BUSYW: begin
        // r/w falls only after busy access time has passed
        if (cnt == '0) begin
          next_pins.rw_n = 1'b0;
          next_cnt = cw(OE_LOW_WRITE != 0 ?
                        dpc_pkg::C_WZD : dpc_pkg::C_WP);
          next_st  = S_WPULSE;
          if (!busy_s2)
            next_blk = 1'b1;
        end
      end
      S_WPULSE: begin
        // data driven only once ram outputs have floated
        if (OE_LOW_WRITE == 0 || cnt <= cw(dpc_pkg::C_DW)) begin
          next_dq_o  = cur.data;
          next_dq_oe = 1'b1;
        end
        if (!busy_s2) begin
          next_blk = 1'b1;
          next_cnt = cw(dpc_pkg::C_WH);
        end else if (cnt == '0 || (blk && cnt == '0)) begin
          next_pins.rw_n = 1'b1;
          next_cnt = cw(dpc_pkg::C_WR);
          next_st  = S_RECOV;
        end
      end
      S_RECOV: begin
        if (cnt == '0) begin
          next_pins.sel_n = 1'b1;
          next_pins.oe_n  = 1'b1;
          next_dq_oe = 1'b0;
          next_rsp.done = 1'b1;
          next_rsp.blocked = blk;
          next_st = S_IDLE;
        end
      end
      S_READ: begin
        if (cnt == '0) begin
          if (!busy_s2)
            next_blk = 1'b1;
          // busy seen only now still needs the full busy-to-data wait
          next_cnt = (blk || !busy_s2) ? cw(dpc_pkg::C_BDD) : '0;
          next_st  = S_RBDD;
        end
      end
      S_RBDD: begin
        if (!busy_s2) begin
          next_blk = 1'b1;
          next_cnt = cw(dpc_pkg::C_BDD);
        end else if (cnt == '0) begin
          next_rsp.rdata = dq_i;
          next_pins.oe_n  = 1'b1;
          next_pins.sel_n = 1'b1;
          next_cnt = cw(dpc_pkg::C_HZ);
          next_st  = S_RFLOAT;
        end
      end
      S_RFLOAT: begin
        if (cnt == '0) begin
          next_rsp.done = 1'b1;
          next_rsp.blocked = blk;
          next_st = S_IDLE;
        end
      end
      default: next_st = S_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st    <= S_IDLE;
      cnt   <= '0;
      cur   <= '0;
      pins  <= '{sel_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: '0};
      dq_o  <= '0;
      dq_oe <= 1'b0;
      req_ready <= 1'b0;
      blk   <= 1'b0;
      rsp   <= '0;
    end else begin
      st    <= next_st;
      cnt   <= next_cnt;
      cur   <= next_cur;
      pins  <= next_pins;
      dq_o  <= next_dq_o;
      dq_oe <= next_dq_oe;
      req_ready <= next_ready;
      blk   <= next_blk;
      rsp   <= next_rsp;
    end
  end
endmodule // dpc_host

// file: verification/dpc_host_asserts.sv
// pin timing checker for the dual-port ram host
`timescale 1ns/1ps
module dpc_host_asserts (
  input wire logic                         clk_sys,    // clock
  input wire logic                         srst,       // reset
  input wire logic                         req_valid,  // strobe
  input wire dpc_pkg::dpc_req_t            req,        // request
  input wire logic                         req_ready,  // idle
  input wire dpc_pkg::dpc_rsp_t            rsp,        // answer
  input wire dpc_pkg::dpc_pins_t           pins,       // ram pins
  input wire logic [dpc_pkg::DATA_W-1:0]   dq_o,       // data out
  input wire logic                         dq_oe,      // data enable
  input wire logic                         busy_n_pin  // busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // write pulse and hold steps
  sequence s_pulse; !pins.rw_n [*3]; endsequence
  sequence s_hold; !pins.rw_n [*4]; endsequence
  property p_addr; !$stable(pins.addr) |-> pins.sel_n || pins.rw_n; endproperty
  a_addr: assert property (p_addr) else $error("addr moved in write");
  property p_wstart;
    $fell(pins.rw_n) |-> !pins.sel_n && $past(pins.sel_n, 4) == 1'b0;
  endproperty
  a_wstart: assert property (p_wstart) else $error("early write");
  property p_pulse; $fell(pins.rw_n) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("short pulse");
  property p_drive; dq_oe |-> pins.oe_n; endproperty
  a_drive: assert property (p_drive) else $error("bus fight");
  property p_hold; !pins.rw_n && $rose(busy_n_pin) |-> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_block;
    $fell(pins.rw_n) && !busy_n_pin |-> ##[1:60] rsp.done && rsp.blocked;
  endproperty
  a_block: assert property (p_block) else $error("busy unseen");
  property p_done; rsp.done |=> !rsp.done; endproperty
  a_done: assert property (p_done) else $error("long done");
  property p_take;
    req_valid && req_ready |=> !req_ready && pins.addr == $past(req.addr);
  endproperty
  a_take: assert property (p_take) else $error("bad accept");
endmodule // dpc_host_asserts

// file: verification/dpc_ram_model.sv
// behavioural model of one port of the dual-port ram
`timescale 1ns/1ps
module dpc_ram_model (
  input  wire logic               clk_sys,  // clock
  input  wire dpc_pkg::dpc_pins_t pins,     // host pins
  input  wire logic [7:0]         dq_o,     // write data
  input  wire logic               dq_oe,    // host drives
  input  wire logic               contend,  // other port won
  output logic [7:0]              dq_i,     // read data
  output logic                    busy_n    // busy to host
);
  logic [7:0] mem [2048] = '{default: 8'h00};
  logic [7:0] last = 8'h00;
  int         rd_cnt = 0;
  initial busy_n = 1'b1;
  // busy, write overlap and read access count
  always @(posedge clk_sys) begin
    busy_n <= !(contend && !pins.sel_n);
    if (!pins.sel_n && !pins.rw_n && busy_n && dq_oe)
      mem[pins.addr] <= dq_o;
    rd_cnt <= (!pins.sel_n && pins.rw_n && !pins.oe_n) ? rd_cnt + 1 : 0;
    last <= dq_i;
  end
  // floating bus toggles, data valid after access, edge rounding
  assign dq_i = (rd_cnt >= dpc_pkg::C_RD - 1 && busy_n) ?
                mem[pins.addr] : ~last;
endmodule // dpc_ram_model

// file: verification/dpc_host_tb.sv
// self-checking bench for the dual-port ram host
`timescale 1ns/1ps
module dpc_host_tb;
  logic               clk_sys = 0, srst = 1, req_valid = 0, contend = 0;
  dpc_pkg::dpc_req_t  req = '0;
  dpc_pkg::dpc_rsp_t  rsp;
  dpc_pkg::dpc_pins_t pins;
  logic [7:0]         dq_o, dq_i, shadow [2048] = '{default: 8'h00};
  logic               req_ready, dq_oe, busy_n;
  logic [31:0]        rnd = 32'h5f30;
  int                 n_fail = 0, comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  dpc_host dpc_host_i (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp(rsp), .pins(pins), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .busy_n_pin(busy_n));
  dpc_ram_model dpc_ram_model_i (.clk_sys(clk_sys), .pins(pins), .dq_o(dq_o),
    .dq_oe(dq_oe), .contend(contend), .dq_i(dq_i), .busy_n(busy_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one request, optionally against a winning opposite port
  task automatic xfer(input logic wr, input logic [10:0] a,
                      input logic [7:0] d, input logic busy);
    int n;
    n = 0;
    req = '{wr, a, d};
    req_valid = 1'b1;
    contend = busy;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 if (n == 10) contend = 1'b0;
    end while (rsp.done !== 1'b1 && ++n < 80);
    check({7'b0, rsp.done}, 8'h01);
    check({7'b0, rsp.blocked}, {7'b0, busy});
    if (wr) shadow[a] = d;
    else check(rsp.rdata, shadow[a]);
  endtask
  // corner cases, then random traffic on a few shared cells
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 srst = 1'b0;
    xfer(1, 11'h000, 8'h5a, 0);
    xfer(1, 11'h7ff, 8'ha5, 0);
    xfer(0, 11'h000, 8'h00, 0);
    xfer(1, 11'h7ff, 8'h3c, 1);
    xfer(0, 11'h7ff, 8'h00, 0);
    xfer(0, 11'h7ff, 8'h00, 1);
    repeat (60) begin
      rnd = lfsr(rnd);
      xfer(rnd[0], {8'h00, rnd[3:1]}, rnd[15:8], rnd[0] & rnd[4]);
    end
    finish_test();
  end
  // watchdog against a hang
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
endmodule // dpc_host_tb
bind dpc_host dpc_host_asserts dpc_host_asserts_i (.clk_sys(clk_sys),
  .srst(srst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp(rsp), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe),
  .busy_n_pin(busy_n_pin));
